// ### hdl/eecl_loader.sv
// Configuration loader top: reads the first EEPROM bytes after reset and
// applies them when the signature is valid; APB slave for status.
// Assumes a byte reader on pclk that answers rom_req with a one-cycle rom_ack.
`timescale 1ns/1ps
`default_nettype none
module eecl_loader #(
  parameter int QW = 8
) (
  input wire logic pclk, // System clock, 50 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address or on a write to any register but 0x0A
  output logic rom_req, // Byte read request, held until ack
  output logic [7:0] rom_addr, // EEPROM byte address
  input wire logic rom_ack, // Byte read done, one cycle
  input wire logic [7:0] rom_data, // Byte read value, valid with ack
  input wire eecl_pkg::eecl_strap_t strap_pins, // Strap pins, asynchronous
  output eecl_pkg::eecl_cfg_t cfg, // Active settings
  output logic [1:0] bp_mode, // Effective backpressure mode
  output logic bp_active, // Backpressure in force
  output logic load_done, // Loading finished
  output logic eeprom_valid, // Signature found
  input wire logic [QW-1:0] bcast_queued, // Broadcasts queued
  input wire logic bcast_pkt_valid, // Incoming broadcast strobe
  output logic bcast_drop // Drop verdict for that packet
);

  // ------------------------------------------------------------
  // Strap synchroniser
  // ------------------------------------------------------------
  eecl_pkg::eecl_strap_t strap_meta;
  eecl_pkg::eecl_strap_t strap_sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_meta <= '0;
      strap_sync <= '0;
    end
    else
    begin
      strap_meta <= strap_pins;
      strap_sync <= strap_meta;
    end
  end

  // ------------------------------------------------------------
  // Load sequencer
  // ------------------------------------------------------------
  eecl_pkg::eecl_state_t state;
  eecl_pkg::eecl_state_t next_state;
  logic [1:0] settle_cnt;
  logic [7:0] byte_idx;
  logic [7:0] rom_image [0:5];
  logic sig_ok;
  logic sig_bad;
  logic last_byte;

  assign sig_ok = (rom_image[0] == eecl_pkg::SIG_BYTE0) &&
                  (rom_image[1] == eecl_pkg::SIG_BYTE1);
  // Abort as soon as byte 1 is in and the pattern fails
  assign sig_bad = (byte_idx == 8'h02) && !sig_ok;
  assign last_byte = byte_idx == eecl_pkg::LOAD_BYTES;

  always_comb
  begin
    next_state = state;
    case (state)
      eecl_pkg::ST_SETTLE:
        if (settle_cnt == eecl_pkg::STRAP_SETTLE)
          next_state = eecl_pkg::ST_STRAP;
      eecl_pkg::ST_STRAP:
        next_state = eecl_pkg::ST_REQ;
      eecl_pkg::ST_REQ:
        if (rom_ack)
          next_state = eecl_pkg::ST_CHECK;
      eecl_pkg::ST_CHECK:
        if (sig_bad)
          next_state = eecl_pkg::ST_DONE;
        else if (last_byte)
          next_state = eecl_pkg::ST_APPLY;
        else
          next_state = eecl_pkg::ST_REQ;
      eecl_pkg::ST_APPLY:
        next_state = eecl_pkg::ST_DONE;
      eecl_pkg::ST_DONE:
        next_state = eecl_pkg::ST_DONE;
      default:
        next_state = eecl_pkg::ST_SETTLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= eecl_pkg::ST_SETTLE;
    else
      state <= next_state;
  end

  // Straps need two edges to clear the synchroniser after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_cnt <= 2'h0;
    else if (state == eecl_pkg::ST_SETTLE)
      settle_cnt <= settle_cnt + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      byte_idx <= 8'h00;
    else if (state == eecl_pkg::ST_REQ && rom_ack)
      byte_idx <= byte_idx + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 6; i++)
        rom_image[i] <= 8'h00;
    else if (state == eecl_pkg::ST_REQ && rom_ack && byte_idx < eecl_pkg::LOAD_BYTES)
      rom_image[byte_idx[2:0]] <= rom_data;
  end

  assign rom_req = state == eecl_pkg::ST_REQ;
  assign rom_addr = byte_idx;

  // ------------------------------------------------------------
  // Settings
  // ------------------------------------------------------------
  eecl_pkg::eecl_cfg_t rom_cfg;
  eecl_pkg::eecl_cfg_t strap_cfg;
  logic [7:0] ctl1;
  logic [7:0] ctl2;

  assign ctl1 = rom_image[eecl_pkg::IDX_SWCTL1[2:0]];
  assign ctl2 = rom_image[eecl_pkg::IDX_SWCTL2[2:0]];
  assign rom_cfg.led_mode = rom_image[eecl_pkg::IDX_LED_SEL[2:0]][eecl_pkg::LED_LSB +: 2];
  assign rom_cfg.pause_en = ctl1[eecl_pkg::PAUSE_BIT];
  assign rom_cfg.bp_en = ctl1[eecl_pkg::BP_EN_BIT];
  assign rom_cfg.mac_flow_en = ctl1[eecl_pkg::MACX_BIT];
  assign rom_cfg.storm_en = ctl1[eecl_pkg::STORM_BIT];
  assign rom_cfg.bp_type = eecl_pkg::eecl_bp_type_t'(ctl2[eecl_pkg::BP_TYPE_LSB +: 2]);

  assign strap_cfg.led_mode = strap_sync.led_sel;
  assign strap_cfg.pause_en = strap_sync.pause_en;
  assign strap_cfg.bp_en = strap_sync.bp_en;
  assign strap_cfg.mac_flow_en = strap_sync.strap_wan_rx_bit0;
  assign strap_cfg.storm_en = strap_sync.storm_en;
  assign strap_cfg.bp_type = eecl_pkg::BP_CARRIER;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg.led_mode <= eecl_pkg::LED_DEFAULT;
      cfg.pause_en <= eecl_pkg::PAUSE_DEFAULT;
      cfg.bp_en <= eecl_pkg::BP_EN_DEFAULT;
      cfg.bp_type <= eecl_pkg::BP_CARRIER;
      cfg.mac_flow_en <= eecl_pkg::MACX_DEFAULT;
      cfg.storm_en <= eecl_pkg::STORM_DEFAULT;
    end
    else if (state == eecl_pkg::ST_STRAP)
      cfg <= strap_cfg;
    else if (state == eecl_pkg::ST_APPLY)
      cfg <= rom_cfg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eeprom_valid <= 1'b0;
    else if (state == eecl_pkg::ST_APPLY)
      eeprom_valid <= 1'b1;
  end

  assign load_done = state == eecl_pkg::ST_DONE;
  assign bp_active = cfg.bp_en;
  // Type is meaningless without the enable; reserved code falls back to carrier
  assign bp_mode = (!cfg.bp_en || cfg.bp_type == eecl_pkg::BP_RESERVED) ?
                   eecl_pkg::BP_CARRIER : cfg.bp_type;

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[9:2] == idx) && (addr[11:10] == 2'h0);
  endfunction : hit

  logic [15:0] cfg_0a;
  logic [15:0] mgmt_12;
  logic [2:0] status_word;
  logic [7:0] rd_byte;
  logic sel_rom;
  logic sel_status;
  logic sel_cfg;
  logic sel_mgmt;
  logic mapped;
  logic wr_cfg;

  assign sel_rom = hit(paddr, eecl_pkg::IDX_SIG_LOW) || hit(paddr, eecl_pkg::IDX_SIG_HIGH) ||
                   hit(paddr, eecl_pkg::IDX_LED_SEL) || hit(paddr, eecl_pkg::IDX_RSVD3) ||
                   hit(paddr, eecl_pkg::IDX_SWCTL1) || hit(paddr, eecl_pkg::IDX_SWCTL2);
  assign sel_status = hit(paddr, eecl_pkg::IDX_STATUS);
  assign sel_cfg = hit(paddr, eecl_pkg::IDX_CFG_0A);
  assign sel_mgmt = hit(paddr, eecl_pkg::IDX_MGMT_12);
  assign mapped = sel_rom || sel_status || sel_cfg || sel_mgmt;
  assign wr_cfg = psel && penable && pwrite && sel_cfg;

  assign mgmt_12 = {cfg.led_mode, cfg.pause_en, cfg.bp_en, cfg.storm_en,
                    cfg.mac_flow_en, 10'h000};
  assign status_word = {eeprom_valid, load_done, rom_req};
  // Byte 3 is reserved and always reads zero
  assign rd_byte = (paddr[4:2] == eecl_pkg::IDX_RSVD3[2:0]) ? 8'h00 :
                   rom_image[paddr[4:2]];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_0a <= eecl_pkg::CFG_0A_RESET;
    else if (wr_cfg)
      cfg_0a <= pwdata[15:0];
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && !sel_cfg));
  assign prdata = sel_rom ? {24'h000000, rd_byte} :
                  sel_status ? {29'h00000000, status_word} :
                  sel_cfg ? {16'h0000, cfg_0a} :
                  sel_mgmt ? {16'h0000, mgmt_12} : 32'h00000000;

  // ------------------------------------------------------------
  // Broadcast storm guard
  // ------------------------------------------------------------
  eecl_storm_guard #(
    .QW(QW)
  ) u_storm (
    .pclk(pclk),
    .presetn(presetn),
    .enable(cfg.storm_en),
    .thr_sel(cfg_0a[eecl_pkg::THR_LSB +: 2]),
    .bcast_queued(bcast_queued),
    .pkt_valid(bcast_pkt_valid),
    .drop(bcast_drop)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_read_sig;
    state == eecl_pkg::ST_CHECK && byte_idx == 8'h02;
  endsequence

  sequence seq_settle;
    state == eecl_pkg::ST_SETTLE [*3];
  endsequence

  AST_SIG_BAD_STOPS: assert property (
    seq_read_sig ##0 !sig_ok |=> state == eecl_pkg::ST_DONE && !eeprom_valid)
    else $error("Bad signature did not end the load");

  AST_APPLY_NEEDS_SIG: assert property (
    state == eecl_pkg::ST_APPLY |-> sig_ok && byte_idx == eecl_pkg::LOAD_BYTES)
    else $error("Settings applied without a full valid image");

  AST_LED_MIRROR: assert property (
    state == eecl_pkg::ST_APPLY |=> mgmt_12[15:14] == $past(rom_image[2][1:0]))
    else $error("LED mode not taken from byte 2");

  AST_PAUSE_MIRROR: assert property (
    state == eecl_pkg::ST_APPLY |=> cfg.pause_en == $past(ctl1[7]) && mgmt_12[13] == cfg.pause_en)
    else $error("Pause enable not taken from byte 4 bit 7");

  AST_BP_GATED: assert property (
    !cfg.bp_en |-> bp_mode == eecl_pkg::BP_CARRIER && !mgmt_12[12])
    else $error("Backpressure type acted while disabled");

  AST_BP_TYPE: assert property (
    state == eecl_pkg::ST_APPLY |=> cfg.bp_type == $past(ctl2[4:3]))
    else $error("Backpressure type not taken from byte 5");

  AST_MACX_MIRROR: assert property (
    state == eecl_pkg::ST_APPLY |=> mgmt_12[10] == $past(ctl1[3]))
    else $error("External MAC flow control not from byte 4 bit 3");

  AST_STORM_DROP: assert property (
    cfg.storm_en && bcast_pkt_valid && bcast_queued > 8'h40 |=> bcast_drop)
    else $error("Broadcast over any threshold not dropped");

  AST_NO_DROP_OFF: assert property (
    !cfg.storm_en |=> !bcast_drop)
    else $error("Drop while storm guard disabled");

  AST_THR_WRITE: assert property (
    wr_cfg |=> cfg_0a[14:13] == $past(pwdata[14:13]))
    else $error("Threshold field not written");

  AST_BP_RESERVED: assert property (
    cfg.bp_type == eecl_pkg::BP_RESERVED |-> bp_mode == eecl_pkg::BP_CARRIER)
    else $error("Reserved backpressure code not treated as carrier");

  AST_STRAP_KEPT: assert property (
    seq_read_sig ##0 !sig_ok |=> $stable(cfg) [*4])
    else $error("Settings changed after a failed signature");

  AST_BAD_NO_MORE_REQ: assert property (
    seq_read_sig ##0 !sig_ok |=> (!rom_req) [*4])
    else $error("Byte requested after a failed signature");

  AST_STRAP_LOAD: assert property (
    state == eecl_pkg::ST_STRAP |=> cfg == $past(strap_cfg))
    else $error("Synchronised straps not taken");

  AST_REQ_AFTER_STRAP: assert property (
    seq_settle ##1 state == eecl_pkg::ST_STRAP |=> rom_req && rom_addr == 8'h00)
    else $error("First byte not requested after the strap cycle");

  AST_REQ_HELD: assert property (
    rom_req && !rom_ack |=> rom_req && $stable(rom_addr))
    else $error("Byte request dropped before its ack");

  AST_VALID_NEEDS_SIG: assert property (
    eeprom_valid |-> sig_ok && load_done)
    else $error("Valid flag without a good signature");

  AST_STORM_BELOW: assert property (
    cfg.storm_en && bcast_pkt_valid && bcast_queued <= 8'h08 |=> !bcast_drop)
    else $error("Broadcast under every threshold dropped");

  AST_BP_TYPE_PASS: assert property (
    cfg.bp_en && cfg.bp_type != eecl_pkg::BP_RESERVED |-> bp_mode == cfg.bp_type)
    else $error("Backpressure type not passed on while enabled");

endmodule : eecl_loader
`default_nettype wire

// ### hdl/eecl_pkg.sv
// Constants, field layout and types of the configuration loader.
// Assumes one clock domain (pclk) and an APB register window.
// ------------------------------------------------------------
// Summary of operation
// ------------------------------------------------------------
// Summary of operation
// - Bytes 0 and 1 must hold 55AA for the EEPROM to count as present.
// - Load EEPROM settings only after power-on reset and only with a valid signature.
// - LED mode from byte 2 bits 1:0, default 3, mirrored at 0x12 bits 15:14.
// - Byte 4 bit 7 enables pause frames, default 1, mirrored at 0x12 bit 13.
// - Byte 4 bit 4 enables backpressure, default 1; type only matters when set.
// - Byte 5 bits 4:3 select carrier, collision with hashing, collision without hashing.
// - Byte 4 bit 3 enables external MAC port flow control, default 1, mirror bit 10.
// - Storm guard drops a packet when queued broadcasts exceed the threshold.
package eecl_pkg;

  localparam logic [7:0] SIG_BYTE0 = 8'h55;
  localparam logic [7:0] SIG_BYTE1 = 8'hAA;
  localparam logic [7:0] LOAD_BYTES = 8'h06;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SIG_LOW = 8'h00;
  localparam logic [7:0] IDX_SIG_HIGH = 8'h01;
  localparam logic [7:0] IDX_LED_SEL = 8'h02;
  localparam logic [7:0] IDX_RSVD3 = 8'h03;
  localparam logic [7:0] IDX_SWCTL1 = 8'h04;
  localparam logic [7:0] IDX_SWCTL2 = 8'h05;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  localparam logic [7:0] IDX_CFG_0A = 8'h0A;
  localparam logic [7:0] IDX_MGMT_12 = 8'h12;

  // EEPROM byte fields
  localparam int LED_LSB = 0;
  localparam int PAUSE_BIT = 7;
  localparam int BP_EN_BIT = 4;
  localparam int MACX_BIT = 3;
  localparam int STORM_BIT = 2;
  localparam int BP_TYPE_LSB = 3;
  // Management register 0x12 mirror positions
  localparam int MIR_LED_LSB = 14;
  localparam int MIR_PAUSE = 13;
  localparam int MIR_BP_EN = 12;
  localparam int MIR_STORM = 11;
  localparam int MIR_MACX = 10;
  // Config register 0x0A storm threshold field
  localparam int THR_LSB = 13;
  localparam logic [15:0] CFG_0A_RESET = 16'h0000;

  // Reset values of the settings
  localparam logic [1:0] LED_DEFAULT = 2'h3;
  localparam logic PAUSE_DEFAULT = 1'b1;
  localparam logic BP_EN_DEFAULT = 1'b1;
  localparam logic MACX_DEFAULT = 1'b1;
  localparam logic STORM_DEFAULT = 1'b0;

  typedef enum logic [1:0] {
    BP_CARRIER = 2'b00,
    BP_COLL_HASH = 2'b01,
    BP_COLL_NOHASH = 2'b10,
    BP_RESERVED = 2'b11
  } eecl_bp_type_t;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b000,
    ST_STRAP = 3'b001,
    ST_REQ = 3'b010,
    ST_CHECK = 3'b011,
    ST_APPLY = 3'b100,
    ST_DONE = 3'b101
  } eecl_state_t;

  typedef struct packed {
    logic [1:0] led_mode;
    logic pause_en;
    logic bp_en;
    eecl_bp_type_t bp_type;
    logic mac_flow_en;
    logic storm_en;
  } eecl_cfg_t;

  // Strap pins, sampled once after reset release
  typedef struct packed {
    logic [1:0] led_sel;
    logic pause_en;
    logic bp_en;
    logic storm_en;
    logic strap_wan_rx_bit0;
  } eecl_strap_t;

endpackage : eecl_pkg

// ### hdl/eecl_storm_guard.sv
// Broadcast storm guard: decides per arriving broadcast packet whether to drop it.
// Assumes queue depth and packet strobes come from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
module eecl_storm_guard #(
  parameter int QW = 8,
  parameter logic [QW-1:0] THR0 = 8'h08,
  parameter logic [QW-1:0] THR1 = 8'h10,
  parameter logic [QW-1:0] THR2 = 8'h20,
  parameter logic [QW-1:0] THR3 = 8'h40
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic enable, // Storm protection on
  input wire logic [1:0] thr_sel, // Threshold code
  input wire logic [QW-1:0] bcast_queued, // Broadcasts now queued
  input wire logic pkt_valid, // Incoming broadcast packet strobe
  output logic drop // Drop verdict, one cycle after the strobe
);

  logic [QW-1:0] threshold;
  logic over;

  assign threshold = (thr_sel == 2'h0) ? THR0 :
                     (thr_sel == 2'h1) ? THR1 :
                     (thr_sel == 2'h2) ? THR2 : THR3;
  // Strictly above, so a queue sitting at the threshold still admits
  assign over = bcast_queued > threshold;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drop <= 1'b0;
    else
      drop <= enable && pkt_valid && over;
  end

endmodule : eecl_storm_guard
`default_nettype wire

// ### testbench/eecl_rom_model.sv
// Byte reader model standing in for the configuration EEPROM.
// Assumes the loader's rom_req/rom_addr handshake on pclk.
`timescale 1ns/1ps
`default_nettype none
module eecl_rom_model (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic rom_req, // Byte request
  input wire logic [7:0] rom_addr, // Byte address
  input wire logic [47:0] image, // Bytes 0..5, byte 0 lowest
  input wire logic [3:0] lag, // Wait cycles before ack
  output logic rom_ack, // One-cycle ack
  output logic [7:0] rom_data // Byte, valid with ack
);
  logic [3:0] wait_cnt;
  logic [7:0] data_q;
  // Off the ack cycle the line shows the inverse, so stale data never passes
  assign rom_data = rom_ack ? data_q : ~data_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 4'h0;
      rom_ack <= 1'b0;
      data_q <= 8'h00;
    end
    else
    begin
      rom_ack <= 1'b0;
      if (rom_req && !rom_ack)
      begin
        if (wait_cnt >= lag)
        begin
          rom_ack <= 1'b1;
          data_q <= image[8*rom_addr[2:0] +: 8];
          wait_cnt <= 4'h0;
        end
        else
        begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule : eecl_rom_model
`default_nettype wire

// ### testbench/tb_eeprom_config_loader.sv
// Self-checking bench of the configuration loader: APB tasks and scenarios.
// Assumes the loader package and the EEPROM model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); end end
module tb_eeprom_config_loader;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_req, rom_ack;
  logic load_done, eeprom_valid, bp_active, bcast_pkt_valid, bcast_drop, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rom_addr, rom_data, bcast_queued, max_addr, ev, thr;
  logic [1:0] bp_mode, ty;
  logic [47:0] image, im;
  logic [3:0] lag;
  eecl_pkg::eecl_strap_t strap_pins;
  eecl_pkg::eecl_cfg_t cfg;
  int n_fail, compares, cycles, i, j, t, c;

  eecl_loader #(.QW(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_req(rom_req),
    .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_data(rom_data),
    .strap_pins(strap_pins), .cfg(cfg), .bp_mode(bp_mode), .bp_active(bp_active),
    .load_done(load_done), .eeprom_valid(eeprom_valid), .bcast_queued(bcast_queued),
    .bcast_pkt_valid(bcast_pkt_valid), .bcast_drop(bcast_drop));
  eecl_rom_model rom (.pclk(pclk), .presetn(presetn), .rom_req(rom_req),
    .rom_addr(rom_addr), .image(image), .lag(lag), .rom_ack(rom_ack),
    .rom_data(rom_data));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Highest byte address requested since reset
  always @(posedge pclk)
  begin
    if (!presetn)
      max_addr <= 8'h00;
    else if (rom_req === 1'b1 && rom_addr > max_addr)
      max_addr <= rom_addr;
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // ----
  // Tasks
  // ----
  task print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    `CHK(pready, 1'b1)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic load(input logic [47:0] img, input logic [5:0] sp, input logic [3:0] lg);
    int k;
    @(posedge pclk);
    image <= img;
    strap_pins <= sp;
    lag <= lg;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    k = 0;
    while (load_done !== 1'b1 && k < 300)
    begin
      @(posedge pclk);
      k++;
    end
    #1;
    `CHK(load_done, 1'b1)
  endtask : load

  task automatic pkt(input logic [7:0] q, input logic d);
    @(posedge pclk);
    bcast_queued <= q;
    bcast_pkt_valid <= 1'b1;
    @(posedge pclk);
    bcast_pkt_valid <= 1'b0;
    #1;
    `CHK(bcast_drop, d)
    @(posedge pclk);
    #1;
    `CHK(bcast_drop, 1'b0)
  endtask : pkt

  function automatic logic [47:0] mk(input logic [15:0] sig, input logic [7:0] b2,
    input logic [7:0] b4, input logic [7:0] b5);
    mk = {b5, b4, 8'hFF, b2, sig[7:0], sig[15:8]};
  endfunction : mk

  // ----
  // Scenarios
  // ----
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap_pins = 6'h00;
    image = 48'h0;
    lag = 4'h0;
    bcast_queued = 8'h00;
    bcast_pkt_valid = 1'b0;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    #1;
    `CHK(cfg, 8'hF2)
    `CHK(rom_req, 1'b0)
    // Broken signatures: straps led 01, storm 1, others 0
    for (i = 0; i < 2; i++)
    begin
      load(mk(i ? 16'hAA55 : 16'h5500, 8'h00, 8'hFF, 8'h08), 6'h12, 4'h1);
      repeat (5) @(posedge pclk);
      #1;
      `CHK(cfg, 8'h41)
      `CHK(eeprom_valid, 1'b0)
      `CHK(max_addr, 8'h01)
    end
    for (t = 0; t < 5; t++)
    begin
      ty = t[1:0] ^ {1'b0, t[2]};
      ev = {t[1:0], t[0], ~t[2], ty, t[1], t[0] ^ t[1]};
      im = mk(16'h55AA, {6'h00, t[1:0]}, {ev[5], 2'b00, ev[4], ev[1], ev[0], 2'b01},
        {3'h0, ty, 3'h0});
      load(im, 6'h00, t[3:0]);
      `CHK(cfg, ev)
      `CHK(eeprom_valid, 1'b1)
      `CHK(max_addr, 8'h05)
      `CHK(bp_active, ev[4])
      `CHK(bp_mode, (ev[4] && ty != 2'b11) ? ty : 2'b00)
      apb(1'b0, 8'h12, 32'h0);
      `CHK(rd[15:10], {ev[7:4], ev[0], ev[1]})
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rd[2:0], 3'b110)
      for (j = 0; j < 6; j++)
      begin
        apb(1'b0, j[7:0], 32'h0);
        `CHK(rd, (j == 3) ? 32'h0 : {24'h0, im[8*j +: 8]})
      end
      pkt(8'hFF, ev[0]);
    end
    // Read-only and unmapped places refuse
    apb(1'b0, 8'h07, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h02, 32'h0000_00FF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h02, 32'h0);
    `CHK(rd, 32'h0)
    load(mk(16'h55AA, 8'h03, 8'h9D, 8'h00), 6'h00, 4'h2);
    apb(1'b0, 8'h0A, 32'h0);
    `CHK(rd, 32'h0)
    for (c = 0; c < 4; c++)
    begin
      apb(1'b1, 8'h0A, {16'h0, 1'b0, c[1:0], 13'h0});
      `CHK(err, 1'b0)
      apb(1'b0, 8'h0A, 32'h0);
      `CHK(rd[14:13], c[1:0])
      thr = 8'h08 << c;
      pkt(thr, 1'b0);
      pkt(thr + 8'h01, 1'b1);
    end
    print_verdict();
  end
endmodule : tb_eeprom_config_loader
`default_nettype wire
